// [rtl/rxc_defines.svh]
/*
 * Constants of the data receiver register bank: offsets, reset values,
 * write masks, field positions and timing counts.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef RXC_DEFINES_SVH
`define RXC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RXC_OFF_PIN_USAGE 7'h07
`define RXC_OFF_RSVD_FIXED 7'h08
`define RXC_OFF_CTRL0 7'h0a
`define RXC_OFF_CTRL1 7'h0b
`define RXC_OFF_CTRL2 7'h0c
`define RXC_OFF_CTRL3 7'h0d
`define RXC_OFF_STATUS 7'h0e
`define RXC_OFF_FIFO_CTRL 7'h11
`define RXC_OFF_FIFO_OFFSET 7'h12

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define RXC_RST_PIN_USAGE 8'h00
`define RXC_RST_RSVD_FIXED 8'h58
`define RXC_RST_CTRL0 8'h40
`define RXC_RST_CTRL1 8'h29
`define RXC_RST_CTRL2 8'h23
`define RXC_RST_CTRL3 8'h04
`define RXC_RST_FIFO_CTRL 8'h00
`define RXC_RST_FIFO_OFFSET 8'h04
`define RXC_WM_PIN_USAGE 8'hc3
`define RXC_WM_CTRL3 8'h07
`define RXC_WM_FIFO_CTRL 8'ha1
`define RXC_WM_FIFO_OFFSET 8'h77

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RXC_USAGE_PARITY 2'h1
`define RXC_USAGE_FRAME 2'h2
`define RXC_BIT_PAR_FLAG 5
`define RXC_BIT_FRM_FLAG 4
`define RXC_BIT_DLL_EN 7
`define RXC_BIT_DCC_EN 6
`define RXC_BIT_WARN_CLR 7
`define RXC_BIT_LOCK_LONG 6
`define RXC_BIT_DCO_EN 6
`define RXC_BIT_ALIGN_REQ 7
`define RXC_BIT_ALIGN_ACK 6
`define RXC_BIT_PIN_FRAMING 5
`define RXC_BIT_PHASE_REPORT 0
`define RXC_DELAY_HIGH_BASE 5'h10

// ----------------------------------------
// Timing
// ----------------------------------------
`define RXC_SYS_PERIOD_NS 4
`define RXC_DCI_WINDOW_NS 1000
`define RXC_DCI_ON_MHZ 100
`define RXC_DCI_WINDOW_CYC (`RXC_DCI_WINDOW_NS / `RXC_SYS_PERIOD_NS)
`define RXC_DCI_ON_EDGES (`RXC_DCI_ON_MHZ * `RXC_DCI_WINDOW_NS / 1000)
`define RXC_DIV_TERM_0 9'h003
`define RXC_DIV_TERM_1 9'h00f
`define RXC_DIV_TERM_2 9'h03f
`define RXC_DIV_TERM_3 9'h1ff

`endif

// [rtl/rxc_pkg.sv]
/*
 * Types of the data receiver register bank: serial port states,
 * configuration and status bundles, and the state of each clock domain.
 * Assumes the constants header is compiled alongside.
 */
package rxc_pkg;

    typedef enum logic [1:0] {
        RXC_SPI_IDLE,
        RXC_SPI_INSTR,
        RXC_SPI_DATA,
        RXC_SPI_DONE
    } rxc_spi_state_t;

    // Settings passed to the link domain
    typedef struct packed {
        logic dll_en;
        logic [3:0] phase_off;
        logic [1:0] div_sel;
        logic [3:0] middle;
        logic [2:0] max_set;
        logic [2:0] min_set;
        logic align_req;
    } rxc_link_cfg_t;

    // Status returned from the link domain
    typedef struct packed {
        logic lock;
        logic near;
        logic at_start;
        logic at_end;
        logic correct;
        logic neg_half;
        logic running;
        logic align_ack;
    } rxc_link_stat_t;

    // Settings driven to the analog and datapath parts
    typedef struct packed {
        logic dcc_enable;
        logic [1:0] dcc_bandwidth;
        logic lock_delay_long;
        logic data_clock_output_oe;
        logic pin_framing_enable;
        logic phase_report_enable;
        logic [2:0] read_pointer_offset;
        logic [2:0] write_pointer_offset;
        logic parity_active_flag;
        logic framing_active_flag;
        logic dll_warn_flag;
    } rxc_cfg_out_t;

    typedef struct packed {
        logic [2:0] sclk_s;
        logic [2:0] cs_s;
        logic [1:0] sdi_s;
        rxc_spi_state_t st;
        logic [2:0] cnt;
        logic rw;
        logic [6:0] addr;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic sdo;
        logic sdo_oe;
        logic [7:0] pin_usage;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] fifo_ctrl;
        logic [7:0] fifo_off;
        logic warn;
        logic wr_pulse;
        rxc_link_stat_t stat_s1;
        rxc_link_stat_t stat_s2;
        logic [2:0] tog_s;
        logic [7:0] win_cnt;
        logic [8:0] edge_cnt;
        logic dci_on;
    } rxc_sys_state_t;

    typedef struct packed {
        rxc_link_cfg_t cfg_s1;
        rxc_link_cfg_t cfg_s2;
        logic [8:0] div_cnt;
        logic tick;
        logic [4:0] delay;
        rxc_link_stat_t stat;
        logic tog;
        logic fifo_reset;
    } rxc_link_state_t;

endpackage

// [rtl/rxc_regbank.sv]
/*
 * Register bank of the source-synchronous data receiver: serial
 * configuration port, receiver and FIFO control, and a delay-line
 * controller model running on the host data clock.
 * Assumes rxc_defines.svh and rxc_pkg are compiled first; serial port
 * pins and the data clock are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "rxc_defines.svh"

// Overview of operation
// - Two-bit usage field picks none, parity, framing or reserved for the pin.
// - Parity-active flag reads 1 only in parity mode with parity checking enabled.
// - Framing-active flag reads 1 only in frame mode with pin framing enabled.
// - Control 0 bit 6 enables duty-cycle correction, reset value 1.
// - Signed-magnitude offset moves locked phase by n steps of 11.25 degrees.
// - Writing 1 to control 1 bit 7 clears the receiver warning.
// - Four-bit field sets nominal middle delay, reset value 9.
// - Control 2 bit 6 enables the data clock output driver.
// - Three-bit field sets maximum delay; larger gives a longer line.
// - Three-bit field sets minimum delay; larger gives a longer line.
// - Two-bit duty-correction bandwidth, 00 highest to 11 lowest, reset 2.
// - Status bits flag near either end, at start and at end.
// - Status bit 3 reads 1 when data is sampled on correct phase.
// - Status bit 2 reads 1 when data clock runs above 100 MHz.
// - Status bit 1 reads 1 when locked on the negative clock half.
// - Status bit 0 shows loop running; otherwise delay held at middle.
// - FIFO control bit 7 requests a FIFO alignment, resetting the FIFO.
// - FIFO control bit 6 follows the request once it has been handled.
// - FIFO control bit 5 enables framing from the hardware frame pin.
// - FIFO control bit 0 enables FIFO phase reporting.
// - Offset register holds read offset bits 6:4 and write offset bits 2:0.
// - The delay-line warning also raises a sticky warning flag.
module rxc_regbank #(
    parameter int DCI_WINDOW_CYC = `RXC_DCI_WINDOW_CYC,
    parameter int DCI_ON_EDGES = `RXC_DCI_ON_EDGES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic parity_check_enable,
    output rxc_pkg::rxc_cfg_out_t rx_cfg,
    input wire logic data_clock_input,
    output logic [4:0] dll_delay_tap,
    output logic fifo_align_reset
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (DCI_WINDOW_CYC < 2 || DCI_WINDOW_CYC > 255) begin : g_bad_window
        $error("DCI_WINDOW_CYC must lie in 2..255");
    end
    if (DCI_ON_EDGES < 1 || DCI_ON_EDGES > 510) begin : g_bad_edges
        $error("DCI_ON_EDGES must lie in 1..510");
    end

    localparam logic [7:0] WIN_LAST = 8'(DCI_WINDOW_CYC - 1);
    localparam logic [8:0] ON_EDGES = 9'(DCI_ON_EDGES);

    rxc_pkg::rxc_sys_state_t s, sn;
    rxc_pkg::rxc_link_state_t l, ln;
    rxc_pkg::rxc_link_cfg_t cfg_bus;
    rxc_pkg::rxc_link_stat_t st;
    logic par_flag;
    logic frm_flag;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] wdata;

    // ----------------------------------------
    // Register decode helpers
    // ----------------------------------------
    function automatic logic is_mapped(input logic [6:0] a);
        is_mapped = (a == `RXC_OFF_PIN_USAGE) || (a == `RXC_OFF_RSVD_FIXED)
            || (a == `RXC_OFF_CTRL0) || (a == `RXC_OFF_CTRL1)
            || (a == `RXC_OFF_CTRL2) || (a == `RXC_OFF_CTRL3)
            || (a == `RXC_OFF_STATUS) || (a == `RXC_OFF_FIFO_CTRL)
            || (a == `RXC_OFF_FIFO_OFFSET);
    endfunction

    function automatic logic [7:0] read_reg(input logic [6:0] a,
                                            input rxc_pkg::rxc_sys_state_t r,
                                            input logic pf, input logic ff);
        logic [7:0] v;
        v = 8'h00;
        if (is_mapped(a)) begin
            unique case (a)
                `RXC_OFF_PIN_USAGE: v = {r.pin_usage[7:6], pf, ff, 2'h0, r.pin_usage[1:0]};
                `RXC_OFF_RSVD_FIXED: v = `RXC_RST_RSVD_FIXED;
                `RXC_OFF_CTRL0: v = r.ctrl0;
                `RXC_OFF_CTRL1: v = r.ctrl1;
                `RXC_OFF_CTRL2: v = r.ctrl2;
                `RXC_OFF_CTRL3: v = r.ctrl3;
                `RXC_OFF_STATUS: v = {r.stat_s2.lock, r.warn, r.stat_s2.at_start,
                                      r.stat_s2.at_end, r.stat_s2.correct, r.dci_on,
                                      r.stat_s2.neg_half, r.stat_s2.running};
                `RXC_OFF_FIFO_CTRL: v = {r.fifo_ctrl[7], r.stat_s2.align_ack,
                                         r.fifo_ctrl[5], 4'h0, r.fifo_ctrl[0]};
                `RXC_OFF_FIFO_OFFSET: v = r.fifo_off;
                default: v = 8'h00;
            endcase
        end
        read_reg = v;
    endfunction

    // ----------------------------------------
    // Derived flags and outputs
    // ----------------------------------------
    assign par_flag = (s.pin_usage[1:0] == `RXC_USAGE_PARITY) && parity_check_enable;
    assign frm_flag = (s.pin_usage[1:0] == `RXC_USAGE_FRAME)
                      && s.fifo_ctrl[`RXC_BIT_PIN_FRAMING];
    assign sclk_rise = s.sclk_s[1] & ~s.sclk_s[2];
    assign sclk_fall = ~s.sclk_s[1] & s.sclk_s[2];
    assign wdata = {s.sh_in[6:0], s.sdi_s[1]};

    assign cfg_bus = '{dll_en: s.ctrl0[`RXC_BIT_DLL_EN], phase_off: s.ctrl0[3:0],
                       div_sel: s.ctrl1[5:4], middle: s.ctrl1[3:0],
                       max_set: s.ctrl2[5:3], min_set: s.ctrl2[2:0],
                       align_req: s.fifo_ctrl[`RXC_BIT_ALIGN_REQ]};

    assign spi_sdo = s.sdo;
    assign spi_sdo_oe = s.sdo_oe;
    assign rx_cfg.dcc_enable = s.ctrl0[`RXC_BIT_DCC_EN];
    assign rx_cfg.dcc_bandwidth = s.ctrl3[2:1];
    assign rx_cfg.lock_delay_long = s.ctrl1[`RXC_BIT_LOCK_LONG];
    assign rx_cfg.data_clock_output_oe = s.ctrl2[`RXC_BIT_DCO_EN];
    assign rx_cfg.pin_framing_enable = s.fifo_ctrl[`RXC_BIT_PIN_FRAMING];
    assign rx_cfg.phase_report_enable = s.fifo_ctrl[`RXC_BIT_PHASE_REPORT];
    assign rx_cfg.read_pointer_offset = s.fifo_off[6:4];
    assign rx_cfg.write_pointer_offset = s.fifo_off[2:0];
    assign rx_cfg.parity_active_flag = par_flag;
    assign rx_cfg.framing_active_flag = frm_flag;
    assign rx_cfg.dll_warn_flag = s.warn;
    assign dll_delay_tap = l.delay;
    assign fifo_align_reset = l.fifo_reset;

    // ----------------------------------------
    // System domain: serial port and registers
    // ----------------------------------------
    always_comb begin
        sn = s;
        sn.sclk_s = {s.sclk_s[1:0], spi_sclk};
        sn.cs_s = {s.cs_s[1:0], spi_cs_n};
        sn.sdi_s = {s.sdi_s[0], spi_sdi};
        sn.stat_s1 = l.stat;
        sn.stat_s2 = s.stat_s1;
        sn.tog_s = {s.tog_s[1:0], l.tog};
        sn.wr_pulse = 1'b0;
        if (s.cs_s[1]) begin
            sn.st = rxc_pkg::RXC_SPI_IDLE;
            sn.cnt = 3'h0;
            sn.sdo_oe = 1'b0;
        end else begin
            unique case (s.st)
                rxc_pkg::RXC_SPI_IDLE: begin
                    sn.st = rxc_pkg::RXC_SPI_INSTR;
                    sn.cnt = 3'h0;
                end
                rxc_pkg::RXC_SPI_INSTR: begin
                    if (sclk_rise) begin
                        sn.sh_in = wdata;
                        sn.cnt = s.cnt + 3'h1;
                        if (s.cnt == 3'h7) begin
                            sn.rw = s.sh_in[6];
                            sn.addr = wdata[6:0];
                            sn.sh_out = read_reg(wdata[6:0], s, par_flag, frm_flag);
                            sn.st = rxc_pkg::RXC_SPI_DATA;
                        end
                    end
                end
                rxc_pkg::RXC_SPI_DATA: begin
                    if (sclk_fall && s.rw) begin
                        sn.sdo = s.sh_out[7];
                        sn.sh_out = {s.sh_out[6:0], 1'b0};
                        sn.sdo_oe = 1'b1;
                    end
                    if (sclk_rise) begin
                        sn.sh_in = wdata;
                        sn.cnt = s.cnt + 3'h1;
                        if (s.cnt == 3'h7) begin
                            sn.st = rxc_pkg::RXC_SPI_DONE;
                            sn.wr_pulse = ~s.rw;
                        end
                    end
                end
                rxc_pkg::RXC_SPI_DONE: begin
                    if (sclk_fall) begin
                        sn.sdo_oe = 1'b0;
                    end
                end
            endcase
        end
        // Register writes; the fixed reserved register ignores writes
        if (sn.wr_pulse) begin
            unique case (s.addr)
                `RXC_OFF_PIN_USAGE: sn.pin_usage = wdata & `RXC_WM_PIN_USAGE;
                `RXC_OFF_CTRL0: sn.ctrl0 = wdata;
                `RXC_OFF_CTRL1: sn.ctrl1 = wdata;
                `RXC_OFF_CTRL2: sn.ctrl2 = wdata;
                `RXC_OFF_CTRL3: sn.ctrl3 = wdata & `RXC_WM_CTRL3;
                `RXC_OFF_FIFO_CTRL: sn.fifo_ctrl = wdata & `RXC_WM_FIFO_CTRL;
                `RXC_OFF_FIFO_OFFSET: sn.fifo_off = wdata & `RXC_WM_FIFO_OFFSET;
                default: sn.pin_usage = s.pin_usage;
            endcase
        end
        // Sticky warning: a new warning wins over the clear
        sn.warn = (s.warn & ~(sn.wr_pulse && s.addr == `RXC_OFF_CTRL1
                   && wdata[`RXC_BIT_WARN_CLR])) | s.stat_s2.near;
        // Data clock rate meter over a fixed window
        if (s.win_cnt == WIN_LAST) begin
            sn.win_cnt = 8'h00;
            sn.edge_cnt = 9'h000;
            sn.dci_on = (s.edge_cnt > ON_EDGES);
        end else begin
            sn.win_cnt = s.win_cnt + 8'h01;
            if ((s.tog_s[1] ^ s.tog_s[2]) && s.edge_cnt != 9'h1ff) begin
                sn.edge_cnt = s.edge_cnt + 9'h001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.sclk_s <= 3'h0;
            s.cs_s <= 3'h7;
            s.st <= rxc_pkg::RXC_SPI_IDLE;
            s.pin_usage <= `RXC_RST_PIN_USAGE;
            s.ctrl0 <= `RXC_RST_CTRL0;
            s.ctrl1 <= `RXC_RST_CTRL1;
            s.ctrl2 <= `RXC_RST_CTRL2;
            s.ctrl3 <= `RXC_RST_CTRL3;
            s.fifo_ctrl <= `RXC_RST_FIFO_CTRL;
            s.fifo_off <= `RXC_RST_FIFO_OFFSET;
        end else begin
            s <= sn;
        end
    end

    // ----------------------------------------
    // Link domain: delay-line controller
    // ----------------------------------------
    rxc_pkg::rxc_link_cfg_t c;
    logic [8:0] div_term;
    logic [4:0] lo_lim;
    logic [4:0] hi_lim;
    logic [4:0] mid;
    logic [4:0] mag;
    logic [4:0] target;
    logic [4:0] dly;

    always_comb begin
        ln = l;
        ln.cfg_s1 = cfg_bus;
        ln.cfg_s2 = l.cfg_s1;
        c = l.cfg_s2;
        ln.tog = ~l.tog;
        unique case (c.div_sel)
            2'h0: div_term = `RXC_DIV_TERM_0;
            2'h1: div_term = `RXC_DIV_TERM_1;
            2'h2: div_term = `RXC_DIV_TERM_2;
            2'h3: div_term = `RXC_DIV_TERM_3;
        endcase
        ln.tick = (l.div_cnt >= div_term);
        ln.div_cnt = ln.tick ? 9'h000 : l.div_cnt + 9'h001;
        lo_lim = {2'h0, c.min_set};
        hi_lim = `RXC_DELAY_HIGH_BASE + {2'h0, c.max_set};
        mid = {1'b0, c.middle};
        mag = {2'h0, c.phase_off[2:0]};
        target = c.phase_off[3] ? ((mag > mid) ? 5'h00 : mid - mag) : mid + mag;
        if (target < lo_lim) begin
            target = lo_lim;
        end
        if (target > hi_lim) begin
            target = hi_lim;
        end
        dly = l.delay;
        if (!c.dll_en) begin
            dly = mid;
        end else if (l.tick) begin
            if (dly < target) begin
                dly = dly + 5'h01;
            end else if (dly > target) begin
                dly = dly - 5'h01;
            end
        end
        if (c.dll_en && dly < lo_lim) begin
            dly = lo_lim;
        end
        if (c.dll_en && dly > hi_lim) begin
            dly = hi_lim;
        end
        ln.delay = dly;
        ln.stat.running = c.dll_en;
        ln.stat.lock = c.dll_en && (dly == target);
        ln.stat.correct = ln.stat.lock;
        ln.stat.neg_half = ln.stat.lock && c.phase_off[3];
        ln.stat.at_start = c.dll_en && (dly == lo_lim);
        ln.stat.at_end = c.dll_en && (dly == hi_lim);
        ln.stat.near = c.dll_en && ((dly <= lo_lim + 5'h01) || (dly + 5'h01 >= hi_lim));
        // Alignment: reset pulse on each request change, echoed on the same edge
        ln.fifo_reset = c.align_req ^ l.stat.align_ack;
        ln.stat.align_ack = c.align_req;
    end

    always_ff @(posedge data_clock_input or negedge reset_n) begin
        if (!reset_n) begin
            l <= '0;
        end else begin
            l <= ln;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_warn_clear_ok:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (sn.wr_pulse && s.addr == `RXC_OFF_CTRL1 && wdata[7] && !s.stat_s2.near)
        |=> !s.warn)
    else $error("warning not cleared by write");

    a_warn_sets_flag:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        s.stat_s2.near |=> s.warn && rx_cfg.dll_warn_flag)
    else $error("warning flag missed a near event");

    a_reserved_read:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (!s.cs_s[1] && s.st == rxc_pkg::RXC_SPI_INSTR && sclk_rise && s.cnt == 3'h7
         && wdata[6:0] == `RXC_OFF_RSVD_FIXED) |=> s.sh_out == `RXC_RST_RSVD_FIXED)
    else $error("fixed register read wrong");

    a_parity_flag:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        rx_cfg.parity_active_flag |-> s.pin_usage[1:0] == 2'h1 && parity_check_enable)
    else $error("parity flag without parity mode");

    a_align_ack_follows:
    assert property (@(posedge data_clock_input) disable iff (!reset_n)
        $changed(l.cfg_s2.align_req) |=>
        (fifo_align_reset && l.stat.align_ack == $past(l.cfg_s2.align_req))
        ##1 !fifo_align_reset)
    else $error("alignment not acknowledged in one cycle");

    a_dll_off_mid:
    assert property (@(posedge data_clock_input) disable iff (!reset_n)
        !l.cfg_s2.dll_en |=> l.delay == {1'b0, $past(l.cfg_s2.middle)} && !l.stat.running)
    else $error("disabled loop not at middle");

    a_div_period:
    assert property (@(posedge data_clock_input) disable iff (!reset_n)
        (l.tick && l.cfg_s2.div_sel == 2'h0 && $stable(l.cfg_s2.div_sel))
        |=> (!l.tick && l.cfg_s2.div_sel == 2'h0) [*3] ##1 l.tick)
    else $error("divide-by-4 tick period wrong");

    a_start_flag:
    assert property (@(posedge data_clock_input) disable iff (!reset_n)
        l.stat.at_start |-> l.stat.near && l.delay == {2'h0, $past(l.cfg_s2.min_set)})
    else $error("start flag without start position");

    a_dci_on_window:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (s.win_cnt == WIN_LAST) |=> s.dci_on == ($past(s.edge_cnt) > ON_EDGES))
    else $error("clock detect mismatch");

endmodule

// [verification/rxc_host_model.sv]
/*
 * Host side of the link: source of the data clock at 48 ns.
 * Assumes the bench raises enable once the link is wanted.
 */
`timescale 1ns/1ps
module rxc_host_model (
    input wire logic enable,
    output logic data_clock_input
);
    // ----------------------------------------
    // Data clock, low while disabled
    // ----------------------------------------
    initial begin
        data_clock_input = 1'b0;
        #7;
        forever #24 data_clock_input = enable ? ~data_clock_input : 1'b0;
    end
endmodule

// [verification/data_receiver_dll_fifo_ctrl_tb.sv]
/*
 * Self-checking bench of the receiver register bank over its serial port.
 * Assumes rxc_defines.svh, rxc_pkg and rxc_regbank compiled first.
 */
`timescale 1ns/1ps
module data_receiver_dll_fifo_ctrl_tb;
    logic sys_clk, reset_n, spi_sclk, spi_cs_n, spi_sdi, parity_check_enable, link_en;
    logic spi_sdo, spi_sdo_oe, data_clock_input, fifo_align_reset;
    logic [4:0] dll_delay_tap;
    logic [7:0] rd;
    logic oe;
    rxc_pkg::rxc_cfg_out_t rx_cfg;
    int mismatches, tests_run, aligns;
    rxc_regbank #(.DCI_WINDOW_CYC(250), .DCI_ON_EDGES(10)) dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .parity_check_enable(parity_check_enable),
        .rx_cfg(rx_cfg), .data_clock_input(data_clock_input), .dll_delay_tap(dll_delay_tap),
        .fifo_align_reset(fifo_align_reset));
    rxc_host_model host (.enable(link_en), .data_clock_input(data_clock_input));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(negedge data_clock_input) if (fifo_align_reset === 1'b1) aligns++;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up();
        if (mismatches == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] wd);
        logic [15:0] w;
        w = {rw, a, wd};
        @(negedge sys_clk) spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_sdi = w[i];
            repeat (10) @(negedge sys_clk);
            spi_sclk = 1'b1;
            if (i < 8) rd[i] = spi_sdo;
            if (i == 0) oe = spi_sdo_oe;
            repeat (10) @(negedge sys_clk);
            spi_sclk = 1'b0;
        end
        repeat (10) @(negedge sys_clk);
        spi_cs_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic [6:0] a, input logic [7:0] e);
        xfer(1'b1, a, 8'h00);
        cmp({7'h0, oe}, 8'h01);
        cmp(rd, e);
    endtask
    task automatic wait_tap(input logic [4:0] t);
        for (int n = 0; n < 2000 && dll_delay_tap !== t; n++) @(negedge sys_clk);
        repeat (60) @(negedge sys_clk);
        cmp({3'h0, dll_delay_tap}, {3'h0, t});
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {mismatches, tests_run, aligns} = '0;
        {reset_n, spi_sclk, spi_sdi, parity_check_enable, link_en} = '0;
        spi_cs_n = 1'b1;
        repeat (12) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(7'h07, 8'h00);
        chk(7'h08, 8'h58);
        chk(7'h0a, 8'h40);
        chk(7'h0b, 8'h29);
        chk(7'h0c, 8'h23);
        chk(7'h0d, 8'h04);
        chk(7'h0e, 8'h00);
        chk(7'h11, 8'h00);
        chk(7'h12, 8'h04);
        chk(7'h30, 8'h00);
        cmp({7'h0, rx_cfg.dcc_enable}, 8'h01);
        // Pin usage codes with parity and framing enabled, then each disabled
        parity_check_enable = 1'b1;
        xfer(1'b0, 7'h11, 8'h21);
        cmp({6'h0, rx_cfg.pin_framing_enable, rx_cfg.phase_report_enable}, 8'h03);
        for (int c = 0; c < 4; c++) begin
            xfer(1'b0, 7'h07, 8'hc0 | 8'(c));
            chk(7'h07, 8'hc0 | 8'(c) | (c == 1 ? 8'h20 : 8'h00) | (c == 2 ? 8'h10 : 8'h00));
        end
        parity_check_enable = 1'b0;
        xfer(1'b0, 7'h07, 8'h01);
        chk(7'h07, 8'h01);
        xfer(1'b0, 7'h11, 8'h00);
        xfer(1'b0, 7'h07, 8'h02);
        chk(7'h07, 8'h02);
        // Plain settings
        xfer(1'b0, 7'h0a, 8'h00);
        cmp({7'h0, rx_cfg.dcc_enable}, 8'h00);
        xfer(1'b0, 7'h0c, 8'h63);
        cmp({7'h0, rx_cfg.data_clock_output_oe}, 8'h01);
        xfer(1'b0, 7'h0d, 8'hff);
        chk(7'h0d, 8'h07);
        cmp({6'h0, rx_cfg.dcc_bandwidth}, 8'h03);
        xfer(1'b0, 7'h12, 8'hff);
        chk(7'h12, 8'h77);
        cmp({2'h0, rx_cfg.read_pointer_offset, rx_cfg.write_pointer_offset}, 8'h3f);
        // Delay loop on a running data clock, divider 4
        link_en = 1'b1;
        xfer(1'b0, 7'h0b, 8'h09);
        xfer(1'b0, 7'h0a, 8'h80);
        wait_tap(5'd9);
        chk(7'h0e, 8'h8d);
        xfer(1'b0, 7'h0a, 8'h82);
        wait_tap(5'd11);
        chk(7'h0e, 8'h8d);
        xfer(1'b0, 7'h0a, 8'h8a);
        wait_tap(5'd7);
        chk(7'h0e, 8'h8f);
        xfer(1'b0, 7'h0c, 8'h67);
        wait_tap(5'd7);
        xfer(1'b1, 7'h0e, 8'h00);
        cmp(rd & 8'h40, 8'h40);
        cmp({7'h0, rx_cfg.dll_warn_flag}, 8'h01);
        xfer(1'b0, 7'h0c, 8'h63);
        xfer(1'b0, 7'h0b, 8'h89);
        chk(7'h0e, 8'h8f);
        xfer(1'b0, 7'h0a, 8'h00);
        wait_tap(5'd9);
        xfer(1'b1, 7'h0e, 8'h00);
        cmp(rd & 8'h01, 8'h00);
        // Alignment request toggled both ways
        xfer(1'b0, 7'h11, 8'ha1);
        repeat (100) @(negedge sys_clk);
        cmp(8'(aligns), 8'h01);
        chk(7'h11, 8'he1);
        xfer(1'b0, 7'h11, 8'h21);
        repeat (100) @(negedge sys_clk);
        cmp(8'(aligns), 8'h02);
        chk(7'h11, 8'h21);
        wrap_up();
    end
    initial begin
        #300us;
        mismatches++;
        wrap_up();
    end
endmodule
